//--- hw/timer_module.v
`include "timer_module_map.vh"

module timer_module (
  // clock, reset, enable
  input wire clk_sys,
  input wire rst,
  input wire ce,
  // configuration
  input wire [2:0] timer_configuration,
  input wire [1:0] counter_a_mode_field,
  input wire [1:0] counter_b_mode_field,
  input wire [7:0] counter_a_prescale,
  input wire [7:0] counter_b_prescale,
  // control writes
  input wire counter_a_enable_set,
  input wire counter_a_enable_clr,
  input wire counter_b_enable_set,
  input wire counter_b_enable_clr,
  input wire counter_a_debug_stall,
  input wire counter_b_debug_stall,
  input wire calendar_clock_enable,
  // load and match writes
  input wire [31:0] counter_a_interval_load,
  input wire counter_a_load_wr,
  input wire [15:0] counter_b_interval_load,
  input wire counter_b_load_wr,
  input wire [31:0] counter_a_match,
  input wire counter_a_match_wr,
  // interrupt mask and clear
  input wire [8:0] interrupt_mask,
  input wire [8:0] interrupt_clear,
  // debug and pin
  input wire cpu_halted,
  input wire capture_compare_pin,
  // status
  output reg counter_a_enable,
  output reg counter_b_enable,
  output reg [31:0] counter_a_value,
  output reg [15:0] counter_b_value,
  output reg [8:0] raw_interrupt_status,
  output reg [8:0] masked_interrupt_status,
  output reg controller_interrupt,
  output reg trigger_a,
  output reg trigger_b
);

  localparam ST_IDLE = 3'b001;
  localparam ST_TIMER = 3'b010;
  localparam ST_CLOCK = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [15:0] load_a_reg;
  reg [15:0] load_b_reg;
  reg [31:0] count_reg;
  reg [31:0] match_reg;
  reg rtc_seen_reg;
  reg [2:0] pin_sync_reg;
  reg [14:0] div_reg;
  reg tick_reg;
  reg ev_timeout_a;
  reg ev_rtc;
  reg clr_a_en;
  reg [8:0] raw_next;
  wire split = (timer_configuration == `CFG_16_SPLIT);
  wire [15:0] a_count;
  wire [15:0] b_count;
  wire [7:0] a_pre;
  wire [7:0] b_pre;
  wire a_to;
  wire b_to;
  wire a_dis;
  wire b_dis;
  wire stall_a = counter_a_debug_stall & cpu_halted;
  wire halt_any = (counter_a_debug_stall | counter_b_debug_stall) & cpu_halted;
  wire clock_run = counter_a_enable & (calendar_clock_enable | ~halt_any);
  wire [31:0] load_cat = {load_b_reg, load_a_reg};

  // mode decode
  always @* begin
    case (timer_configuration)
      `CFG_32_TIMER: state_next = ST_TIMER;
      `CFG_32_RTC: state_next = ST_CLOCK;
      default: state_next = ST_IDLE;
    endcase
  end

  // pin: two flops before logic, third for the edge
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_sync_reg <= 3'b000;
      div_reg <= 15'h0000;
      tick_reg <= 1'b0;
    end else if (ce) begin
      pin_sync_reg <= {pin_sync_reg[1:0], capture_compare_pin};
      tick_reg <= 1'b0;
      if (state_reg != ST_CLOCK || !counter_a_enable) begin
        div_reg <= 15'h0000;
      end else if (pin_sync_reg[1] & ~pin_sync_reg[2]) begin
        div_reg <= div_reg + 15'h0001;
        tick_reg <= (div_reg == `RTC_DIV_LAST);
      end
    end
  end

  // split-mode counters
  half_counter u_half_a (
    .clk_sys(clk_sys), .rst(rst), .ce(ce),
    .active(split), .enable(counter_a_enable), .mode(counter_a_mode_field),
    .load(counter_a_interval_load[15:0]), .load_wr(counter_a_load_wr),
    .prescale(counter_a_prescale), .stall(stall_a),
    .count_reg(a_count), .pre_reg(a_pre),
    .timeout_pulse(a_to), .disable_pulse(a_dis)
  );

  half_counter u_half_b (
    .clk_sys(clk_sys), .rst(rst), .ce(ce),
    .active(split), .enable(counter_b_enable), .mode(counter_b_mode_field),
    .load(counter_b_interval_load), .load_wr(counter_b_load_wr),
    .prescale(counter_b_prescale), .stall(counter_b_debug_stall & cpu_halted),
    .count_reg(b_count), .pre_reg(b_pre),
    .timeout_pulse(b_to), .disable_pulse(b_dis)
  );

  // 32-bit engine
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      load_a_reg <= `LOAD_RESET;
      load_b_reg <= `LOAD_RESET;
      count_reg <= {`COUNT_RESET, `COUNT_RESET};
      match_reg <= 32'h00000000;
      rtc_seen_reg <= 1'b0;
      ev_timeout_a <= 1'b0;
      ev_rtc <= 1'b0;
      clr_a_en <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      ev_timeout_a <= 1'b0;
      ev_rtc <= 1'b0;
      clr_a_en <= 1'b0;
      if (counter_a_match_wr) begin
        match_reg <= counter_a_match;
      end
      if (counter_a_load_wr) begin
        load_a_reg <= counter_a_interval_load[15:0];
        if (!split) begin
          load_b_reg <= counter_a_interval_load[31:16];
        end
      end else if (counter_b_load_wr && split) begin
        load_b_reg <= counter_b_interval_load;
      end
      case (state_reg)
        ST_TIMER: begin
          if (counter_a_load_wr) begin
            count_reg <= counter_a_interval_load;
          // no step while the one-shot disable lands, so the count rests on its reload
          end else if (counter_a_enable && !stall_a && !clr_a_en) begin
            if (count_reg == 32'h00000000) begin
              count_reg <= load_cat;
              ev_timeout_a <= 1'b1;
              clr_a_en <= (counter_a_mode_field == `MODE_ONE_SHOT);
            end else begin
              count_reg <= count_reg - 32'h00000001;
            end
          end
        end
        ST_CLOCK: begin
          // the clock enable lets wall time run on through a debug halt
          if (state_reg != state_next) begin
            count_reg <= count_reg;
          end else if (!rtc_seen_reg) begin
            rtc_seen_reg <= 1'b1;
            count_reg <= `RTC_FIRST_LOAD;
          end else if (counter_a_match_wr && !counter_a_enable) begin
            count_reg <= counter_a_match;
          end else if (tick_reg && clock_run) begin
            if (count_reg == match_reg) begin
              count_reg <= 32'h00000000;
              ev_rtc <= 1'b1;
            end else begin
              count_reg <= count_reg + 32'h00000001;
            end
          end
        end
        ST_IDLE: begin
          count_reg <= count_reg;
        end
        default: begin
          count_reg <= count_reg;
        end
      endcase
    end
  end

  // flags: a hardware set wins over a same-cycle clear
  always @* begin
    raw_next = raw_interrupt_status & ~interrupt_clear;
    raw_next[`IRQ_A_TIMEOUT] = (raw_interrupt_status[`IRQ_A_TIMEOUT]
      & ~interrupt_clear[`IRQ_A_TIMEOUT]) | ev_timeout_a | a_to;
    raw_next[`IRQ_RTC] = (raw_interrupt_status[`IRQ_RTC]
      & ~interrupt_clear[`IRQ_RTC]) | ev_rtc;
    raw_next[`IRQ_B_TIMEOUT] = (raw_interrupt_status[`IRQ_B_TIMEOUT]
      & ~interrupt_clear[`IRQ_B_TIMEOUT]) | b_to;
  end

  // registered outputs
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      counter_a_enable <= 1'b0;
      counter_b_enable <= 1'b0;
      counter_a_value <= {`COUNT_RESET, `COUNT_RESET};
      counter_b_value <= `COUNT_RESET;
      raw_interrupt_status <= 9'h000;
      masked_interrupt_status <= 9'h000;
      controller_interrupt <= 1'b0;
      trigger_a <= 1'b0;
      trigger_b <= 1'b0;
    end else if (ce) begin
      if (counter_a_enable_set) begin
        counter_a_enable <= 1'b1;
      end else if (counter_a_enable_clr || clr_a_en || a_dis) begin
        counter_a_enable <= 1'b0;
      end
      if (counter_b_enable_set && split) begin
        counter_b_enable <= 1'b1;
      end else if (counter_b_enable_clr || b_dis || !split) begin
        counter_b_enable <= 1'b0;
      end
      if (split) begin
        counter_a_value <= {16'h0000, a_count};
        counter_b_value <= b_count;
      end else begin
        counter_a_value <= count_reg;
        counter_b_value <= count_reg[31:16];
      end
      raw_interrupt_status <= raw_next;
      masked_interrupt_status <= raw_next & interrupt_mask;
      controller_interrupt <= |(raw_next & interrupt_mask);
      trigger_a <= ev_timeout_a | a_to;
      trigger_b <= b_to;
    end
  end

endmodule

//--- inc/timer_module_map.vh
`ifndef TIMER_MODULE_MAP_VH
`define TIMER_MODULE_MAP_VH

// configuration codes
`define CFG_32_TIMER 3'h0
`define CFG_32_RTC 3'h1
`define CFG_16_SPLIT 3'h4

// counter mode field codes
`define MODE_ONE_SHOT 2'h1
`define MODE_PERIODIC 2'h2

// reset values and the first clock-mode count
`define COUNT_RESET 16'hffff
`define LOAD_RESET 16'hffff
`define PRESCALE_RESET 8'h00
`define RTC_FIRST_LOAD 32'h00000001

// real-time clock divider: 32768 input edges per second
`define RTC_DIV_LAST 15'h7fff

// interrupt bit positions
`define IRQ_A_TIMEOUT 0
`define IRQ_RTC 3
`define IRQ_B_TIMEOUT 8

`endif

//--- hw/half_counter.v
`include "timer_module_map.vh"

// one 16-bit down-counter used in split configuration
module half_counter (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  input wire ce,
  // control
  input wire active,
  input wire enable,
  input wire [1:0] mode,
  input wire [15:0] load,
  input wire load_wr,
  input wire [7:0] prescale,
  input wire stall,
  // status
  output reg [15:0] count_reg,
  output reg [7:0] pre_reg,
  output reg timeout_pulse,
  output reg disable_pulse
);

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_reg <= `COUNT_RESET;
      pre_reg <= `PRESCALE_RESET;
      timeout_pulse <= 1'b0;
      disable_pulse <= 1'b0;
    end else if (ce) begin
      timeout_pulse <= 1'b0;
      disable_pulse <= 1'b0;
      if (active && load_wr) begin
        count_reg <= load;
        pre_reg <= prescale;
      // the pulse blocks one step so a one-shot rests on its reload value
      end else if (active && enable && !stall && !disable_pulse) begin
        if (pre_reg != 8'h00) begin
          pre_reg <= pre_reg - 8'h01;
        end else if (count_reg == 16'h0000) begin
          count_reg <= load;
          pre_reg <= prescale;
          timeout_pulse <= 1'b1;
          disable_pulse <= (mode == `MODE_ONE_SHOT);
        end else begin
          count_reg <= count_reg - 16'h0001;
          pre_reg <= prescale;
        end
      end
    end
  end

endmodule

//--- test/timer_module_asserts.sv
module timer_module_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // controls
  input wire logic [2:0] timer_configuration,
  input wire logic [1:0] counter_a_mode_field,
  input wire logic counter_a_enable_clr,
  input wire logic counter_a_debug_stall,
  input wire logic counter_a_load_wr,
  input wire logic [8:0] interrupt_mask,
  input wire logic [8:0] interrupt_clear,
  input wire logic cpu_halted,
  // status
  input wire logic counter_a_enable,
  input wire logic [31:0] counter_a_value,
  input wire logic [8:0] raw_interrupt_status,
  input wire logic [8:0] masked_interrupt_status,
  input wire logic controller_interrupt,
  input wire logic trigger_a
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire t32 = timer_configuration == 3'h0;
  // stall needs three cycles because the visible value lags the count by one
  sequence halted_s;
    t32 && counter_a_debug_stall && cpu_halted && !counter_a_load_wr;
  endsequence
  sequence running_s;
    t32 && ce && counter_a_mode_field == 2'h2 && counter_a_enable && !counter_a_enable_clr
      && !cpu_halted && !counter_a_load_wr && counter_a_value != 32'h0;
  endsequence
  AST_IRQ: assert property (controller_interrupt == |masked_interrupt_status)
    else $error("interrupt differs from masked flags");
  AST_MASK_SUB: assert property ((masked_interrupt_status & ~raw_interrupt_status) == 9'h0)
    else $error("masked flag without raw flag");
  AST_MASK_SET: assert property ($rose(raw_interrupt_status[0]) && interrupt_mask[0]
    |-> masked_interrupt_status[0]) else $error("masked timeout missing");
  AST_RAW_HOLD: assert property (raw_interrupt_status[0] && !interrupt_clear[0]
    |=> raw_interrupt_status[0]) else $error("timeout flag dropped");
  AST_CLK_CLEAR: assert property (ce && interrupt_clear[3] && !counter_a_enable
    |=> !raw_interrupt_status[3] && !masked_interrupt_status[3]) else $error("match flag kept");
  AST_TRIG_ONE: assert property (trigger_a |=> !trigger_a)
    else $error("trigger longer than one cycle");
  AST_TRIG_RAW: assert property (trigger_a |-> raw_interrupt_status[0])
    else $error("trigger without timeout flag");
  AST_ONESHOT: assert property (trigger_a && t32 && counter_a_mode_field == 2'h1
    |-> ##[0:4] !counter_a_enable) else $error("one-shot kept enable");
  AST_PERIODIC: assert property (t32 && ce && counter_a_mode_field == 2'h2 && counter_a_enable
    && !counter_a_enable_clr |=> counter_a_enable) else $error("periodic lost enable");
  AST_DOWN: assert property (running_s[*2] ##1 ce
    |-> counter_a_value == $past(counter_a_value) - 32'h1) else $error("count not down by one");
  AST_STALL: assert property (halted_s[*3] |-> $stable(counter_a_value))
    else $error("count moved in debug halt");
endmodule

bind timer_module timer_module_asserts chk (.clk_sys, .rst, .ce, .timer_configuration,
  .counter_a_mode_field, .counter_a_enable_clr, .counter_a_debug_stall, .counter_a_load_wr,
  .interrupt_mask, .interrupt_clear, .cpu_halted, .counter_a_enable, .counter_a_value,
  .raw_interrupt_status, .masked_interrupt_status, .controller_interrupt, .trigger_a);

//--- test/ccp_source.sv
module ccp_source (
  // control
  input wire logic run,
  // pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  parameter real HALF_NS = 15258.789;
  initial pin = 1'b0;
  // stands still when idle so no stray edges reach the divider
  always begin
    wait (run);
    #(HALF_NS) pin = ~pin;
  end
endmodule

//--- test/test_timer_module.sv
module test_timer_module;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [1:0] md; logic [31:0] ld; logic mk;} row_t;
  // periodic rows run with mode b set to one-shot, which must not matter
  row_t rows [4] = '{'{2'h2, 32'h20, 1'b1}, '{2'h2, 32'h7, 1'b0},
                     '{2'h1, 32'h15, 1'b1}, '{2'h1, 32'h2, 1'b0}};
  logic clk_sys = 0, rst = 1, ce = 1, a_set = 0, a_clr = 0, b_set = 0, stall_a = 0;
  logic halted = 0, cal_en = 0, ld_a = 0, ld_b = 0, m_wr = 0, pin_run = 0;
  logic [2:0] cfg = 3'h0;
  logic [1:0] mode_a = 2'h1, mode_b = 2'h1;
  logic [31:0] load_a = 0, match = 0, v;
  logic [15:0] load_b = 0;
  logic [8:0] mask = 9'h0, clr = 9'h0;
  wire pin, en_a, en_b, irq, trig_a, trig_b;
  wire [31:0] val_a;
  wire [15:0] val_b;
  wire [8:0] raw, msk;
  int bad_count = 0, checked = 0, n;
  always #20 clk_sys = ~clk_sys;
  ccp_source src (.run(pin_run), .pin(pin));
  timer_module dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .timer_configuration(cfg),
    .counter_a_mode_field(mode_a), .counter_b_mode_field(mode_b),
    .counter_a_prescale(8'h00), .counter_b_prescale(8'h00), .counter_a_enable_set(a_set),
    .counter_a_enable_clr(a_clr), .counter_b_enable_set(b_set), .counter_b_enable_clr(1'b0),
    .counter_a_debug_stall(stall_a), .counter_b_debug_stall(1'b0),
    .calendar_clock_enable(cal_en), .counter_a_interval_load(load_a),
    .counter_a_load_wr(ld_a), .counter_b_interval_load(load_b), .counter_b_load_wr(ld_b),
    .counter_a_match(match), .counter_a_match_wr(m_wr), .interrupt_mask(mask),
    .interrupt_clear(clr), .cpu_halted(halted), .capture_compare_pin(pin),
    .counter_a_enable(en_a), .counter_b_enable(en_b), .counter_a_value(val_a),
    .counter_b_value(val_b), .raw_interrupt_status(raw), .masked_interrupt_status(msk),
    .controller_interrupt(irq), .trigger_a(trig_a), .trigger_b(trig_b));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // returns cycles since the call, so two calls in a row give the period
  task wait_trig(input logic on_b, output int cyc);
    cyc = 1;
    tick(1);
    while (!(on_b ? trig_b : trig_a) && cyc < 3000) begin
      tick(1);
      cyc++;
    end
    if (cyc >= 3000) bad_count++;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task start_a(input logic [31:0] ld);
    load_a = ld;
    ld_a = 1; tick(1); ld_a = 0;
    a_set = 1; tick(1); a_set = 0;
  endtask
  initial begin
    #2_000_000;
    bad_count++;
    end_sim;
  end
  initial begin
    tick(5);
    rst = 0;
    tick(2);
    foreach (rows[i]) begin
      mode_a = rows[i].md;
      mask = {5'h0, 1'b1, 2'h0, rows[i].mk};
      start_a(rows[i].ld);
      wait_trig(1'b0, n);
      check(raw[0], 1'b1);
      check(msk[0], rows[i].mk);
      check(irq, rows[i].mk);
      if (rows[i].md == 2'h2) begin
        wait_trig(1'b0, n);
        check(n, rows[i].ld + 32'h1);
        check(en_a, 1'b1);
      end else begin
        tick(5);
        check(en_a, 1'b0);
        check(val_a, rows[i].ld);
      end
      a_clr = 1; clr = 9'h001; tick(1); a_clr = 0; clr = 9'h000; tick(2);
      check(raw[0], 1'b0);
      check(irq, 1'b0);
      $display("row %0d done", i);
    end
    rst = 1; tick(2);
    check(val_a, 32'hffffffff);
    check(val_b, 16'hffff);
    check({en_a, en_b, irq, raw}, 12'h000);
    rst = 0; tick(2);
    load_a = 32'h0003_0021; ld_a = 1; tick(1); ld_a = 0; tick(3);
    check(val_a, 32'h0003_0021);
    check(val_b, 16'h0003);
    $display("reset and pairing done");
    mode_a = 2'h2;
    start_a(32'h40);
    tick(10);
    load_a = 32'h0c; ld_a = 1; tick(1); ld_a = 0;
    wait_trig(1'b0, n);
    check(n < 16, 1'b1);
    wait_trig(1'b0, n);
    check(n, 32'h0d);
    stall_a = 1; halted = 1; tick(2); v = val_a; tick(20);
    check(val_a, v);
    halted = 0; tick(3);
    check(val_a === v, 1'b0);
    a_clr = 1; tick(1); a_clr = 0; stall_a = 0;
    $display("reload and stall done");
    cfg = 3'h4; mode_a = 2'h1; mode_b = 2'h2; tick(2);
    load_a = 32'h80; load_b = 16'h18; ld_a = 1; ld_b = 1; tick(1); ld_a = 0; ld_b = 0;
    a_set = 1; b_set = 1; tick(1); a_set = 0; b_set = 0;
    wait_trig(1'b1, n);
    wait_trig(1'b1, n);
    check(n, 32'h19);
    check(en_a, 1'b1);
    check(val_a[31:16], 16'h0);
    a_clr = 1; tick(1); a_clr = 0;
    $display("split done");
    cfg = 3'h1; cal_en = 1; pin_run = 1; halted = 1; tick(3);
    check(val_a, 32'h1);
    match = 32'h100; m_wr = 1; tick(1); m_wr = 0; tick(3);
    check(val_a, 32'h100);
    clr = 9'h008; tick(1); clr = 9'h000; tick(2);
    check(raw[3], 1'b0);
    $display("clock mode done");
    end_sim;
  end
endmodule
